// ---- hw/emp_host.sv ----
// Host controller that drives the muxed-bus memory pins from Wishbone registers.
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns

module emp_host import emp_pkg::*; #(
    parameter logic [15:0] PAGE_WINDOW = 16'(PAGE_WINDOW_CYC)
) (
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Device pins.
    output logic addr_latch_o,
    output logic chip_select_n_o,
    output logic program_fetch_strobe_n_o,
    output logic read_strobe_n_o,
    output logic write_strobe_n_o,
    output logic write_commit_n_o,
    output logic [4:0] high_order_address_o,
    input wire logic [7:0] muxed_addr_data_bus_i,
    output logic [7:0] muxed_addr_data_bus_o,
    output logic muxed_addr_data_bus_oe_o
);

    typedef struct packed {
        emp_state_t st;
        emp_op_t op;
        logic abort;
        logic second;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [7:0] first;
        logic toggling;
        logic page_err;
        logic [7:0] page_base;
        logic [15:0] page_tmr;
        logic [3:0] hold_tmr;
        logic [3:0] cnt;
        logic ale;
        logic cs_n;
        logic program_fetch_strobe_n_n;
        logic rd_n;
        logic wr_n;
        logic wc_n;
        logic [4:0] hi_addr;
        logic [7:0] bus_out;
        logic bus_oe;
        logic ack;
        logic [31:0] dat;
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
    } emp_regs_t;

    emp_regs_t q_r;
    emp_regs_t q_nxt;

    logic req;
    logic go;
    logic page_open;

    assign req = wb_cyc_i & wb_stb_i & ~q_r.ack;
    assign page_open = (q_r.page_tmr != 16'h0000) | (q_r.hold_tmr != 4'h0);

    always_comb begin
        q_nxt = q_r;
        go = 1'b0;
        q_nxt.s1 = muxed_addr_data_bus_i;
        q_nxt.s2 = q_r.s1;
        q_nxt.s3 = q_r.s2;

        // Wishbone register access; every access is acked on the first ce_i-enabled cycle after it starts.
        q_nxt.ack = req;
        if (req && !wb_we_i) begin
            if (wb_adr_i == REG_ADDR) begin
                q_nxt.dat = {19'h0, q_r.addr};
            end else if (wb_adr_i == REG_WDATA) begin
                q_nxt.dat = {24'h0, q_r.wdata};
            end else if (wb_adr_i == REG_STATUS) begin
                q_nxt.dat = 32'h0;
                q_nxt.dat[ST_RDATA_LSB +: 8] = q_r.rdata;
                q_nxt.dat[ST_PAGE_ERR_BIT] = q_r.page_err;
                q_nxt.dat[ST_PAGE_OPEN_BIT] = page_open;
                q_nxt.dat[ST_TOGGLING_BIT] = q_r.toggling;
                q_nxt.dat[ST_BUSY_BIT] = (q_r.st != ST_IDLE);
            end else begin
                q_nxt.dat = 32'h0;
            end
        end else if (req && wb_we_i) begin
            if (wb_adr_i == REG_ADDR) begin
                if (wb_sel_i[0]) q_nxt.addr[7:0] = wb_dat_i[7:0];
                if (wb_sel_i[1]) q_nxt.addr[ADDR_W-1:8] = wb_dat_i[ADDR_W-1:8];
            end else if (wb_adr_i == REG_WDATA) begin
                if (wb_sel_i[0]) q_nxt.wdata = wb_dat_i[7:0];
            end else if (wb_adr_i == REG_CMD) begin
                if (wb_sel_i[0] && q_r.st == ST_IDLE) begin
                    // Guard and lock sequences reach the device as ordinary writes.
                    go = 1'b1;
                    q_nxt.op = emp_op_t'(wb_dat_i[CMD_OP_LSB +: 2]);
                    q_nxt.abort = wb_dat_i[CMD_ABORT_BIT];
                end
            end else if (wb_adr_i == REG_STATUS) begin
                if (wb_sel_i[0] && wb_dat_i[ST_PAGE_ERR_BIT]) q_nxt.page_err = 1'b0;
            end
        end

        // Page window then commit hold; commit returns high once both are spent, or at once when a write is aborted.
        if (q_r.page_tmr != 16'h0000) begin
            q_nxt.page_tmr = q_r.page_tmr - 16'h0001;
            if (q_r.page_tmr == 16'h0001) q_nxt.hold_tmr = COMMIT_HOLD_CYC;
        end else if (q_r.hold_tmr != 4'h0) begin
            q_nxt.hold_tmr = q_r.hold_tmr - 4'h1;
        end else if (q_r.st == ST_IDLE) begin
            q_nxt.wc_n = 1'b1;
        end

        case (q_r.st)
            ST_IDLE: begin
                if (go) begin
                    // A write that leaves the open page is refused and flagged.
                    if (q_nxt.op == OP_WRITE && page_open &&
                        q_r.addr[ADDR_W-1:PAGE_LSB] != q_r.page_base) begin
                        q_nxt.page_err = 1'b1;
                    end else begin
                        q_nxt.st = ST_ADDR;
                        q_nxt.second = 1'b0;
                        q_nxt.cs_n = 1'b0;
                        q_nxt.ale = 1'b1;
                        q_nxt.bus_out = q_r.addr[7:0];
                        q_nxt.bus_oe = 1'b1;
                        q_nxt.hi_addr = q_r.addr[ADDR_W-1:8];
                        q_nxt.cnt = ALE_CYC;
                        if (q_nxt.op == OP_WRITE) q_nxt.wc_n = 1'b0;
                    end
                end
            end
            ST_ADDR: begin
                if (q_r.cnt > 4'h1) begin
                    q_nxt.cnt = q_r.cnt - 4'h1;
                end else begin
                    q_nxt.ale = 1'b0;
                    q_nxt.st = ST_LATCH;
                end
            end
            ST_LATCH: begin
                q_nxt.cnt = STROBE_CYC;
                q_nxt.st = ST_STROBE;
                if (q_r.op == OP_WRITE) begin
                    q_nxt.bus_out = q_r.wdata;
                    q_nxt.wr_n = 1'b0;
                    q_nxt.page_tmr = PAGE_WINDOW;
                    q_nxt.page_base = q_r.addr[ADDR_W-1:PAGE_LSB];
                end else begin
                    q_nxt.bus_oe = 1'b0;
                    if (q_r.op == OP_FETCH) begin
                        q_nxt.program_fetch_strobe_n_n = 1'b0;
                    end else begin
                        q_nxt.rd_n = 1'b0;
                    end
                end
            end
            ST_STROBE: begin
                if (q_r.cnt > 4'h1) begin
                    q_nxt.cnt = q_r.cnt - 4'h1;
                end else if (q_r.op == OP_WRITE) begin
                    q_nxt.wr_n = 1'b1;
                    q_nxt.st = ST_RECOV;
                end else begin
                    q_nxt.st = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                // The byte is taken once the last two synchroniser stages agree.
                if (q_r.s2 == q_r.s3) begin
                    q_nxt.rdata = q_r.s3;
                    q_nxt.program_fetch_strobe_n_n = 1'b1;
                    q_nxt.rd_n = 1'b1;
                    q_nxt.st = ST_RECOV;
                end
            end
            ST_RECOV: begin
                q_nxt.bus_oe = 1'b0;
                q_nxt.cs_n = 1'b1;
                q_nxt.st = ST_IDLE;
                if (q_r.op == OP_WRITE && q_r.abort) begin
                    q_nxt.wc_n = 1'b1;
                    q_nxt.page_tmr = 16'h0000;
                    q_nxt.hold_tmr = 4'h0;
                end else if (q_r.op == OP_POLL && !q_r.second) begin
                    // Second read of the pair; bit 6 differing means programming runs.
                    q_nxt.second = 1'b1;
                    q_nxt.first = q_r.rdata;
                    q_nxt.st = ST_ADDR;
                    q_nxt.cs_n = 1'b0;
                    q_nxt.ale = 1'b1;
                    q_nxt.bus_out = q_r.addr[7:0];
                    q_nxt.bus_oe = 1'b1;
                    q_nxt.cnt = ALE_CYC;
                end else if (q_r.op == OP_POLL) begin
                    q_nxt.toggling = q_r.first[TOGGLE_BIT] ^ q_r.rdata[TOGGLE_BIT];
                end
            end
            default: begin
                q_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= '0;
            q_r.st <= ST_IDLE;
            q_r.op <= OP_FETCH;
            q_r.rdata <= RESET_BYTE;
            q_r.cs_n <= 1'b1;
            q_r.program_fetch_strobe_n_n <= 1'b1;
            q_r.rd_n <= 1'b1;
            q_r.wr_n <= 1'b1;
            q_r.wc_n <= 1'b1;
        end else if (ce_i) begin
            q_r <= q_nxt;
        end
    end

    assign wb_dat_o = q_r.dat;
    assign wb_ack_o = q_r.ack;
    assign addr_latch_o = q_r.ale;
    assign chip_select_n_o = q_r.cs_n;
    assign program_fetch_strobe_n_o = q_r.program_fetch_strobe_n_n;
    assign read_strobe_n_o = q_r.rd_n;
    assign write_strobe_n_o = q_r.wr_n;
    assign write_commit_n_o = q_r.wc_n;
    assign high_order_address_o = q_r.hi_addr;
    assign muxed_addr_data_bus_o = q_r.bus_out;
    assign muxed_addr_data_bus_oe_o = q_r.bus_oe;

endmodule // emp_host

// ---- shared/emp_pkg.sv ----
// Package with constants and types for the muxed-bus memory host controller.
// Contract
// - Fetch read with read/write strobes high.
// - Data read holds fetch/write strobes high.
// - Write data presented, captured on strobe rise.
// - Commit held low during every write.
// - Chip select low before latch strobe falls.
// - Chip select held low whole fetch access.
// - Six byte sequence locks or unlocks blocks.
// - Guard on: three byte sequence precedes writes.
// - Next page byte within 100us.
// - Address bits 5..12 fixed within page.
package emp_pkg;

    localparam int unsigned CLK_NS = 10;

    // Register byte offsets.
    localparam logic [3:0] REG_ADDR = 4'h0;
    localparam logic [3:0] REG_WDATA = 4'h4;
    localparam logic [3:0] REG_CMD = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;

    // Command register fields.
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_ABORT_BIT = 4;

    // Status register fields.
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_TOGGLING_BIT = 1;
    localparam int unsigned ST_PAGE_OPEN_BIT = 2;
    localparam int unsigned ST_PAGE_ERR_BIT = 3;
    localparam int unsigned ST_RDATA_LSB = 8;
    localparam int unsigned TOGGLE_BIT = 6;

    // Address geometry: 8192 bytes, page field is address bits 12..5.
    localparam int unsigned ADDR_W = 13;
    localparam int unsigned PAGE_LSB = 5;

    // Pin timing.
    localparam int unsigned ALE_NS = 20;
    localparam int unsigned ACCESS_NS = 100;
    localparam int unsigned LAST_WRITE_TO_PROGRAM_NS = 100;
    localparam int unsigned PAGE_WINDOW_US = 100;
    localparam logic [3:0] ALE_CYC = 4'((ALE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] STROBE_CYC = 4'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] COMMIT_HOLD_CYC =
        4'((LAST_WRITE_TO_PROGRAM_NS + CLK_NS - 1) / CLK_NS);
    localparam int unsigned PAGE_WINDOW_CYC = (PAGE_WINDOW_US * 1000) / CLK_NS;

    // Reset values.
    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [1:0] {
        OP_FETCH = 2'b00,
        OP_READ = 2'b01,
        OP_WRITE = 2'b10,
        OP_POLL = 2'b11
    } emp_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_LATCH = 3'b010,
        ST_STROBE = 3'b011,
        ST_SAMPLE = 3'b100,
        ST_RECOV = 3'b101
    } emp_state_t;

endpackage

// ---- sim/emp_host_properties.sv ----
// Checker of pin sequencing for the muxed-bus memory host.
`timescale 1ns/1ns
module emp_host_properties (
    // Watched ports.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic addr_latch_o,
    input wire logic chip_select_n_o,
    input wire logic program_fetch_strobe_n_o,
    input wire logic read_strobe_n_o,
    input wire logic write_strobe_n_o,
    input wire logic write_commit_n_o,
    input wire logic muxed_addr_data_bus_oe_o
);
    wire ale = addr_latch_o;
    wire cs_n = chip_select_n_o;
    wire pf_n = program_fetch_strobe_n_o;
    wire rd_n = read_strobe_n_o;
    wire wr_n = write_strobe_n_o;
    wire oe = muxed_addr_data_bus_oe_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_cs_first; $rose(ale) |-> !cs_n; endproperty
    a_cs_first: assert property (p_cs_first) else $error("select late");
    property p_ale_len; $rose(ale) |=> ale ##1 !ale; endproperty
    a_ale_len: assert property (p_ale_len) else $error("latch width");
    property p_addr; ale |-> oe && !cs_n; endproperty
    a_addr: assert property (p_addr) else $error("address not driven");
    property p_fetch; !pf_n |-> rd_n && wr_n && !cs_n && !oe; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch strobes");
    property p_read; !rd_n |-> pf_n && wr_n && !cs_n && !oe; endproperty
    a_read: assert property (p_read) else $error("read strobes");
    property p_write; !wr_n |-> rd_n && pf_n && !write_commit_n_o && oe; endproperty
    a_write: assert property (p_write) else $error("write strobes");
    property p_hold; $rose(wr_n) |-> oe ##[1:2] !oe; endproperty
    a_hold: assert property (p_hold) else $error("write data hold");
    property p_wr_len; $fell(wr_n) |=> !wr_n [*8]; endproperty
    a_wr_len: assert property (p_wr_len) else $error("write strobe short");
endmodule // emp_host_properties
bind emp_host emp_host_properties u_props (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .addr_latch_o(addr_latch_o),
    .chip_select_n_o(chip_select_n_o),
    .program_fetch_strobe_n_o(program_fetch_strobe_n_o),
    .read_strobe_n_o(read_strobe_n_o),
    .write_strobe_n_o(write_strobe_n_o),
    .write_commit_n_o(write_commit_n_o),
    .muxed_addr_data_bus_oe_o(muxed_addr_data_bus_oe_o)
);

// ---- sim/emp_dev_model.sv ----
// Behavioural model of the byte-wide memory device on the muxed bus.
`timescale 1ns/1ns
module emp_dev_model #(
    parameter int PWIN = 30,
    parameter int PROG = 200
) (
    // Timer clock and device pins.
    input wire logic clk_i,
    input wire logic ale_i,
    input wire logic cs_n_i,
    input wire logic pf_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic wc_n_i,
    input wire logic [4:0] hi_i,
    input wire logic [7:0] bus_i,
    output logic [7:0] bus_o,
    output logic oe_o
);
    logic [7:0] mem [8192];
    logic [12:0] lat;
    logic [20:0] q [$];
    logic wr_q = 1'b1, wc_q = 1'b1, tog = 1'b0;
    int idle = 0, prog = 0;
    // Block lock mask; nothing in the model writes it, so the pins never clear it.
    logic [7:0] lock_mask = 8'h80;
    initial foreach (mem[i]) mem[i] = 8'hff;
    always_latch if (ale_i) lat <= {hi_i, bus_i};
    assign oe_o = !cs_n_i && !ale_i &&
        wr_n_i && (pf_n_i != rd_n_i);
    assign bus_o = prog > 0 ? {mem[lat][7], tog, mem[lat][5:0]} : mem[lat];
    always @(negedge oe_o) tog <= !tog;
    always @(posedge clk_i) begin
        wr_q <= wr_n_i;
        wc_q <= wc_n_i;
        if (wr_n_i && !wr_q && !cs_n_i && !wc_n_i && prog == 0) begin
            // The guard is off in this model, so a plain write is queued.
            q.push_back({lat, bus_i});
        end
        if (!wr_n_i && wr_q) begin
            idle <= 0;
        end else if (q.size() > 0) begin
            idle <= idle + 1;
        end
        if (wc_n_i && !wc_q) begin
            q.delete();
        end else if (q.size() > 0 && idle == PWIN) begin
            foreach (q[i]) begin
                if (!lock_mask[q[i][20:18]]) mem[q[i][20:8]] = q[i][7:0];
            end
            q.delete();
            prog <= PROG;
        end else if (prog > 0) begin
            prog <= prog - 1;
        end
    end
endmodule // emp_dev_model

// ---- sim/tb_eeprom_muxed_bus_port.sv ----
// Self-checking bench for the muxed-bus memory host controller.
`timescale 1ns/1ns
module tb_eeprom_muxed_bus_port;
    import emp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [7:0] last = 8'h00;
    wire [31:0] dat_o;
    wire ack, ale, cs_n, pf_n, rd_n, wr_n, wc_n, h_oe, d_oe;
    wire [4:0] hi;
    wire [7:0] h_o, d_o, bus;
    int bad_count = 0;
    int checks = 0;
    // A released bus shows the inverse of its last driven value.
    assign bus = h_oe ? h_o : d_oe ? d_o : ~last;
    always @(posedge clk) if (h_oe || d_oe) last <= bus;
    initial forever #5 clk = ~clk;
    emp_host #(.PAGE_WINDOW(16'h0028)) DUT (
        .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .addr_latch_o(ale), .chip_select_n_o(cs_n), .program_fetch_strobe_n_o(pf_n),
        .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .write_commit_n_o(wc_n),
        .high_order_address_o(hi), .muxed_addr_data_bus_i(bus), .muxed_addr_data_bus_o(h_o),
        .muxed_addr_data_bus_oe_o(h_oe));
    emp_dev_model #(.PWIN(30), .PROG(200)) u_dev (
        .clk_i(clk), .ale_i(ale), .cs_n_i(cs_n), .pf_n_i(pf_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .wc_n_i(wc_n), .hi_i(hi), .bus_i(bus), .bus_o(d_o), .oe_o(d_oe));
    task automatic tally_and_finish();
        if (bad_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
    endtask
    task automatic op(input logic [12:0] a, input logic [4:0] cmd, input logic [7:0] d);
        wb(1'b1, REG_ADDR, 32'(a));
        wb(1'b1, REG_WDATA, 32'(d));
        wb(1'b1, REG_CMD, 32'(cmd));
        do wb(1'b0, REG_STATUS, 32'h0); while (rdat[ST_BUSY_BIT] !== 1'b0);
    endtask
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
        for (int i = 0; i < 2; i++) begin
            op(a, 5'(i), 8'h00);
            chk(rdat[15:8], e);
        end
    endtask
    task automatic s_reset_idle();
        chk({1'b0, ale, cs_n, pf_n, rd_n, wr_n, wc_n, h_oe}, 8'h3e);
        wb(1'b0, 4'h2, 32'h0);
        chk(rdat[7:0] | rdat[31:24], 8'h00);
    endtask
    task automatic s_write_poll();
        op(13'h1a5, 5'(OP_WRITE), 8'h3c);
        repeat (60) @(posedge clk);
        op(13'h1a5, 5'(OP_POLL), 8'h00);
        chk(8'(rdat[ST_TOGGLING_BIT]), 8'h01);
        repeat (250) @(posedge clk);
        op(13'h1a5, 5'(OP_POLL), 8'h00);
        chk(8'(rdat[ST_TOGGLING_BIT]), 8'h00);
        rd_chk(13'h1a5, 8'h3c);
    endtask
    task automatic s_abort();
        op(13'h0b0, 5'h10 | 5'(OP_WRITE), 8'h77);
        repeat (300) @(posedge clk);
        rd_chk(13'h0b0, 8'hff);
    endtask
    task automatic s_page();
        op(13'h200, 5'(OP_WRITE), 8'h11);
        op(13'h201, 5'(OP_WRITE), 8'h22);
        op(13'h300, 5'(OP_WRITE), 8'h33);
        chk(8'(rdat[ST_PAGE_ERR_BIT]), 8'h01);
        wb(1'b1, REG_STATUS, 32'h8);
        repeat (300) @(posedge clk);
        rd_chk(13'h200, 8'h11);
        chk(8'(rdat[ST_PAGE_ERR_BIT]), 8'h00);
        rd_chk(13'h201, 8'h22);
        rd_chk(13'h300, 8'hff);
    endtask
    task automatic s_lock();
        op(13'h1c10, 5'(OP_WRITE), 8'h5a);
        repeat (300) @(posedge clk);
        rd_chk(13'h1c10, 8'hff);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        s_reset_idle();
        rd_chk(13'h1fff, 8'hff);
        s_write_poll();
        s_abort();
        s_page();
        s_lock();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
endmodule // tb_eeprom_muxed_bus_port
